// *** logic/flash_cmd_device.sv ***
/*
  Device end: command interpreter of a serial flash. Decodes opcodes,
  streams the identification bytes, runs the four-byte software reset and
  judges each opcode against the class rules.
  Assumes the array engine reports its self-timed class and raises suspend
  pulses; link pins are asynchronous and are synchronised here.
*/
// Our own choices: the address map and the Avalon-MM register port.
// How it works
// - opcode 9F starts identification output
// - order: maker, two device, length, extended
// - length byte reads 01, one byte follows
// - after extended byte, output floats
// - select release ends read, floats output
// - host keeps identification clock under limit
// - device bytes: family/density, sub/variant fields
// - extended byte: three zero bits, revision
// - F0 plus three zeros aborts program/erase
// - bytes past the fourth are ignored
// - aborted page content is not guaranteed
// - reset spares protection, lockdown, page size
// - reset clears both program-suspend and erase-suspend
// - reset cancels erase suspend, block undefined
// - reset cancels program suspend, page undefined
// - reset only on full bytes, all four
// - opcodes sorted into classes A to D
// - host starts nothing during class A read
// - class C accepted during self-timed class B
// - host sends only status during class D
// - class A accepted while class B suspended
`timescale 1ns/1ps
module flash_cmd_device
  import flash_cmd_pkg::*;
#(
  // identity fields; all values arbitrary
  parameter logic [7:0] MANUFACTURER_CODE = 8'h5A,
  parameter logic [2:0] FAMILY_CODE       = 3'h5,
  parameter logic [4:0] DENSITY_CODE      = 5'h0B,
  parameter logic [2:0] SUB_CODE          = 3'h2,
  parameter logic [4:0] PRODUCT_VARIANT   = 5'h03,
  parameter logic [4:0] SILICON_REVISION  = 5'h07
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  spi_link_if.device      link,
  input  wire logic       b_self_timed,       // class B array cycle running
  input  wire logic       d_self_timed,       // class D register cycle running
  input  wire logic       suspend_prog_one,   // pulse: program via buffer 1 suspended
  input  wire logic       suspend_prog_two,   // pulse: program via buffer 2 suspended
  input  wire logic       suspend_erase,      // pulse: erase suspended
  input  wire logic       resume,             // pulse: suspension resumed
  output logic            program_suspend_buf_one,
  output logic            program_suspend_buf_two,
  output logic            erase_suspend_flag,
  output logic            array_abort,        // pulse: stop program/erase now
  output logic            page_undefined,     // pulse: aborted page left undefined
  output logic            cmd_strobe,         // pulse: an opcode arrived
  output logic [7:0]      cmd_opcode,
  output cmd_class_t      cmd_class,
  output logic            cmd_allowed,
  output logic            id_active           // identification stream in progress
);

  typedef enum logic [4:0] {
    FRAME_IDLE   = 5'h01,  // select high
    FRAME_OPCODE = 5'h02,  // waiting for the first byte
    FRAME_ID     = 5'h04,  // streaming identification
    FRAME_RESET  = 5'h08,  // collecting reset bytes
    FRAME_OTHER  = 5'h10   // command handled elsewhere
  } frame_t;

  typedef struct packed {
    logic [2:0] sclk_s;        // synchroniser chains
    logic [2:0] cs_s;
    logic [2:0] mosi_s;
    logic       sclk_f;        // filtered pin levels
    logic       cs_f;
    logic       mosi_f;
    frame_t     frame;
    logic [7:0] shift;         // incoming byte
    logic [2:0] bit_cnt;       // bits of the current byte
    logic [2:0] byte_cnt;      // whole bytes, saturating at four
    logic       reset_ok;      // trailing reset bytes all zero so far
    logic [5:0] id_bit;        // identification bits already driven
    logic       so;
    logic       so_oe;
    logic       ps_one;
    logic       ps_two;
    logic       erase_susp;
    logic       abort;
    logic       page_undef;
    logic       strobe;
    logic [7:0] opcode;
    cmd_class_t cls;
    logic       allowed;
  } dev_state_t;

  // fixed identification stream, first bit at the top
  localparam logic [39:0] ID_WORD = {MANUFACTURER_CODE,
                                     FAMILY_CODE, DENSITY_CODE,
                                     SUB_CODE, PRODUCT_VARIANT,
                                     EXT_INFO_LENGTH,
                                     reserved_bits, SILICON_REVISION};

  dev_state_t q;        // current state
  dev_state_t next_q;   // next state

  // class rules against the array engine's state
  function automatic logic judge(input logic [7:0] op, input cmd_class_t c,
                                 input logic b_run, input logic d_run, input logic susp);
    logic ok;
    ok = 1'b1;
    if (op == OP_SW_RESET) begin
      ok = 1'b1;                                      // abort must always get through
    end else if (d_run) begin
      ok = (op == OP_STATUS) || (op == OP_STATUS_OLD);
    end else if (b_run) begin
      ok = (c == CLASS_C) || (op == OP_SUSPEND);
    end else if (susp) begin
      ok = (c != CLASS_B) && (c != CLASS_D);
    end
    return ok;
  endfunction : judge

  // next-state logic
  always_comb begin
    logic       sclk_new;
    logic       cs_new;
    logic       mosi_new;
    logic [7:0] byte_in;
    sclk_new = q.sclk_f;
    cs_new   = q.cs_f;
    mosi_new = q.mosi_f;
    byte_in  = {q.shift[6:0], q.mosi_f};
    next_q = q;
    next_q.abort      = 1'b0;
    next_q.page_undef = 1'b0;
    next_q.strobe     = 1'b0;

    // three-stage chains; a level counts once stages two and three agree
    next_q.sclk_s = {q.sclk_s[1:0], link.sclk};
    next_q.cs_s   = {q.cs_s[1:0], link.cs_n};
    next_q.mosi_s = {q.mosi_s[1:0], link.mosi};
    if (q.sclk_s[1] == q.sclk_s[2]) sclk_new = q.sclk_s[2];
    if (q.cs_s[1] == q.cs_s[2]) cs_new = q.cs_s[2];
    if (q.mosi_s[1] == q.mosi_s[2]) mosi_new = q.mosi_s[2];
    next_q.sclk_f = sclk_new;
    next_q.cs_f   = cs_new;
    next_q.mosi_f = mosi_new;
    byte_in = {q.shift[6:0], mosi_new};

    if (cs_new) begin
      // frame end: any bit position ends the read
      next_q.so_oe = 1'b0;
      if (!q.cs_f && q.frame == FRAME_RESET && q.reset_ok &&
          q.byte_cnt == RESET_BYTES && q.bit_cnt == 3'h0) begin
        // only suspend state and the running cycle are touched;
        // protection, lockdown and page size live outside this block
        next_q.abort      = 1'b1;
        next_q.page_undef = b_self_timed | q.ps_one | q.ps_two | q.erase_susp;
        next_q.ps_one     = 1'b0;
        next_q.ps_two     = 1'b0;
        next_q.erase_susp = 1'b0;
      end
      next_q.frame = FRAME_IDLE;
    end else if (q.frame == FRAME_IDLE) begin
      // frame start; host leaves half a period before the first edge
      next_q.frame    = FRAME_OPCODE;
      next_q.bit_cnt  = 3'h0;
      next_q.byte_cnt = 3'h0;
      next_q.reset_ok = 1'b1;
      next_q.id_bit   = 6'h00;
    end else if (sclk_new && !q.sclk_f) begin
      // rising edge: sample, most significant bit first
      next_q.shift   = byte_in;
      next_q.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7) begin
        if (q.byte_cnt != RESET_BYTES) next_q.byte_cnt = q.byte_cnt + 3'h1;
        unique case (q.frame)
          FRAME_OPCODE: begin
            next_q.strobe  = 1'b1;
            next_q.opcode  = byte_in;
            next_q.cls     = classify(byte_in);
            next_q.allowed = judge(byte_in, classify(byte_in), b_self_timed,
                                   d_self_timed, q.ps_one | q.ps_two | q.erase_susp);
            if (byte_in == OP_ID_READ) begin
              next_q.frame = FRAME_ID;
            end else if (byte_in == OP_SW_RESET) begin
              next_q.frame = FRAME_RESET;
            end else begin
              next_q.frame = FRAME_OTHER;
            end
          end
          FRAME_RESET: begin
            // bytes past the fourth no longer count
            if (q.byte_cnt != RESET_BYTES && byte_in != 8'h00) begin
              next_q.reset_ok = 1'b0;
            end
          end
          FRAME_ID, FRAME_OTHER, FRAME_IDLE: begin
            next_q.reset_ok = q.reset_ok;                         // no byte action
          end
        endcase
      end
    end else if (!sclk_new && q.sclk_f && q.frame == FRAME_ID) begin
      // falling edge: drive the next identification bit
      if (q.id_bit != ID_BITS) begin
        next_q.so     = ID_WORD[ID_LAST_BIT - q.id_bit];
        next_q.so_oe  = 1'b1;
        next_q.id_bit = q.id_bit + 6'h01;
      end else begin
        next_q.so_oe = 1'b0;
      end
    end

    // suspend flags: a set in the same cycle as a clear wins
    if (resume) begin
      next_q.ps_one = 1'b0;
      next_q.ps_two = 1'b0;
      next_q.erase_susp = 1'b0;
    end
    if (suspend_prog_one) next_q.ps_one = 1'b1;
    if (suspend_prog_two) next_q.ps_two = 1'b1;
    if (suspend_erase) next_q.erase_susp = 1'b1;
  end

  // state register; select and clock chains rest at their idle levels
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q        <= '0;
      q.cs_s   <= 3'h7;
      q.cs_f   <= 1'b1;
      q.frame  <= FRAME_IDLE;
      q.cls    <= CLASS_NONE;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign link.so                 = q.so;
  assign link.so_oe              = q.so_oe;
  assign program_suspend_buf_one = q.ps_one;
  assign program_suspend_buf_two = q.ps_two;
  assign erase_suspend_flag      = q.erase_susp;
  assign array_abort             = q.abort;
  assign page_undefined          = q.page_undef;
  assign cmd_strobe              = q.strobe;
  assign cmd_opcode              = q.opcode;
  assign cmd_class               = q.cls;
  assign cmd_allowed             = q.allowed;
  assign id_active               = (q.frame == FRAME_ID);

endmodule : flash_cmd_device

// *** logic/flash_cmd_host.sv ***
/*
  Host end: serial controller driven by software over Avalon-MM. Software
  loads up to four bytes, sets a bit count and a clock divider, starts a
  frame and reads back the last forty bits received.
  Assumes one system clock; the returning data line is synchronised here.
*/
`timescale 1ns/1ps
module flash_cmd_host
  import flash_cmd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  spi_link_if.host         link,
  input  wire logic [4:0]  address,      // byte address
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest
);

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,  // select high, waiting for start
    H_LOW  = 5'h02,  // clock low half period
    H_HIGH = 5'h04,  // clock high half period
    H_TAIL = 5'h08,  // hold after the last bit
    H_GAP  = 5'h10   // select high before the next frame
  } host_phase_t;

  typedef struct packed {
    logic [2:0]  miso_s;     // synchroniser chain
    logic        miso_f;     // filtered line level
    host_phase_t phase;
    logic [8:0]  cnt;        // half-period countdown
    logic [8:0]  half;       // half period of this frame
    logic [6:0]  bits_left;
    logic [31:0] tx;         // outgoing bits, zero filled
    logic [39:0] rx;         // last forty bits received
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        ack;
    logic [31:0] rdata;
  } host_state_t;

  host_state_t q;       // current state
  host_state_t next_q;  // next state

  // next-state logic
  always_comb begin
    logic [8:0] half_new;
    half_new = {1'b0, q.div} + 9'h001;
    // identification frames never beat the identification clock limit
    if (q.tx[31:24] == OP_ID_READ && half_new < ID_HALF_CYCLES) begin
      half_new = ID_HALF_CYCLES;
    end
    next_q = q;
    next_q.miso_s = {q.miso_s[1:0], link.miso};
    if (q.miso_s[1] == q.miso_s[2]) next_q.miso_f = q.miso_s[2];

    // bus slave: one wait cycle, answer on the second edge
    next_q.ack = (read | write) & ~q.ack;
    if (read && !q.ack) begin
      unique case (address)
        REG_CTRL:  next_q.rdata = {31'h0, q.phase != H_IDLE};
        REG_TX:    next_q.rdata = q.tx;
        REG_DIV:   next_q.rdata = {24'h0, q.div};
        REG_RX_LO: next_q.rdata = q.rx[31:0];
        REG_RX_HI: next_q.rdata = {24'h0, q.rx[39:32]};
        default:   next_q.rdata = 32'h0;
      endcase
    end
    if (write && q.ack) begin
      if (address == REG_DIV) next_q.div = writedata[7:0];
      // contents are shifted out, so loads are taken only while the engine is idle
      if (address == REG_TX && q.phase == H_IDLE) next_q.tx = writedata;
      if (address == REG_CTRL && q.phase == H_IDLE && writedata[6:0] != 7'h00) begin
        next_q.phase     = H_LOW;
        next_q.cs_n      = 1'b0;
        next_q.mosi      = q.tx[31];
        next_q.half      = half_new;
        next_q.cnt       = half_new;
        next_q.bits_left = writedata[6:0];
        next_q.rx        = 40'h0;
      end
    end

    // serial engine, mode 0: drive on falling, sample on rising
    unique case (q.phase)
      H_IDLE: begin
        next_q.sclk = 1'b0;
      end
      H_LOW: begin
        next_q.cnt = q.cnt - 9'h001;
        if (q.cnt == 9'h001) begin
          next_q.sclk  = 1'b1;
          next_q.rx    = {q.rx[38:0], q.miso_f};
          next_q.phase = H_HIGH;
          next_q.cnt   = q.half;
        end
      end
      H_HIGH: begin
        next_q.cnt = q.cnt - 9'h001;
        if (q.cnt == 9'h001) begin
          next_q.sclk      = 1'b0;
          next_q.tx        = {q.tx[30:0], 1'b0};
          next_q.mosi      = q.tx[30];
          next_q.bits_left = q.bits_left - 7'h01;
          next_q.phase     = (q.bits_left == 7'h01) ? H_TAIL : H_LOW;
          next_q.cnt       = q.half;
        end
      end
      H_TAIL: begin
        next_q.cnt = q.cnt - 9'h001;
        if (q.cnt == 9'h001) begin
          // release lands on the bit count software chose
          next_q.cs_n  = 1'b1;
          next_q.phase = H_GAP;
          next_q.cnt   = q.half;
        end
      end
      H_GAP: begin
        next_q.cnt = q.cnt - 9'h001;
        if (q.cnt == 9'h001) next_q.phase = H_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q        <= '0;
      q.miso_s <= 3'h7;
      q.miso_f <= 1'b1;
      q.phase  <= H_IDLE;
      q.div    <= DIV_RESET;
      q.cs_n   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign link.sclk   = q.sclk;
  assign link.cs_n   = q.cs_n;
  assign link.mosi   = q.mosi;
  assign readdata    = q.rdata;
  assign waitrequest = (read | write) & ~q.ack;

endmodule : flash_cmd_host

// *** logic/flash_cmd_pkg.sv ***
/*
  Shared constants for the serial flash command interpreter and its host
  controller: opcodes, command classes, identification layout, host register
  map and clock figures.
  Assumes a single 20 MHz system clock on both ends.
*/
package flash_cmd_pkg;

  // system clock and identification clock ceiling
  localparam int CLOCK_HZ                 = 20_000_000;
  localparam int MAX_SERIAL_CLOCK_RATE_HZ = 1_000_000;   // plain default
  // least half period in system clocks, rounded up so the limit is never beaten
  localparam logic [8:0] ID_HALF_CYCLES =
    9'((CLOCK_HZ + 2 * MAX_SERIAL_CLOCK_RATE_HZ - 1) / (2 * MAX_SERIAL_CLOCK_RATE_HZ));

  // opcodes this block reacts to
  localparam logic [7:0] OP_ID_READ    = 8'h9F;
  localparam logic [7:0] OP_SW_RESET   = 8'hF0;
  localparam logic [7:0] OP_STATUS     = 8'hD7;
  localparam logic [7:0] OP_STATUS_OLD = 8'h57;
  localparam logic [7:0] OP_SUSPEND    = 8'hB0;

  // identification stream
  localparam logic [7:0] EXT_INFO_LENGTH = 8'h01;
  localparam logic [5:0] ID_BITS        = 6'h28;  // five bytes
  localparam logic [5:0] ID_LAST_BIT    = 6'h27;
  localparam logic [2:0] reserved_bits  = 3'h0;
  localparam logic [2:0] RESET_BYTES    = 3'h4;

  // host register byte offsets
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_TX    = 5'h04;
  localparam logic [4:0] REG_DIV   = 5'h08;
  localparam logic [4:0] REG_RX_LO = 5'h0C;
  localparam logic [4:0] REG_RX_HI = 5'h10;
  localparam logic [7:0] DIV_RESET = 8'h0F;

  // command classes
  typedef enum logic [4:0] {
    CLASS_NONE = 5'h01,
    CLASS_A    = 5'h02,
    CLASS_B    = 5'h04,
    CLASS_C    = 5'h08,
    CLASS_D    = 5'h10
  } cmd_class_t;

  // sort an opcode into its class; multi-byte sequences go by their first byte
  function automatic cmd_class_t classify(input logic [7:0] op);
    cmd_class_t c;
    c = CLASS_NONE;
    case (op)
      8'hD2, 8'h01, 8'h03, 8'h0B, 8'h1B, 8'hE8, 8'hD1, 8'hD3, 8'hD4, 8'hD6,
      8'h32, 8'h35, 8'h77, 8'h54, 8'h56, 8'h52, 8'h68: c = CLASS_A;
      8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85, 8'h02, 8'h81, 8'h50, 8'h7C,
      8'hC7, 8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59: c = CLASS_B;
      8'h84, 8'h87, 8'hD7, 8'h57, 8'h9F:               c = CLASS_C;
      8'h3D, 8'h34, 8'h9B:                             c = CLASS_D;
      default:                                         c = CLASS_NONE;
    endcase
    return c;
  endfunction : classify

endpackage : flash_cmd_pkg

// *** logic/spi_link_if.sv ***
/*
  Serial link between host controller and flash command interpreter.
  Assumes both ends run on the same system clock; the serial clock is a
  plain signal. A weak pull-up holds the data line high while nobody drives.
*/
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;    // serial clock, made by the host
  logic cs_n;    // frame select, active low
  logic mosi;    // host to device data
  logic so;      // device output value
  logic so_oe;   // device drives so while high
  wire  miso;    // resolved line level

  // floating line reads as the pull-up level
  assign miso = so_oe ? so : 1'b1;

  modport device (input sclk, input cs_n, input mosi, output so, output so_oe);
  modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_link_if

// *** tb/flash_id_reset_cmd_arbiter_bench.sv ***
/*
  Bench: host and device joined by the link, driven over Avalon-MM.
  Assumes the package constants and the host register map of the design.
*/
`timescale 1ns/1ps
module flash_id_reset_cmd_arbiter_bench;
  import flash_cmd_pkg::*;
  // identity values, all arbitrary
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] DEV1 = 8'hD1;  // family 6, density 11
  localparam logic [7:0] DEV2 = 8'h2A;  // sub 1, variant 0A
  localparam logic [7:0] EXT_INFO = 8'h15;   // reserved zero, revision 15
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  susp = 4'h0;  // suspend one, two, erase, resume pulses
  logic        b_st = 1'b0;
  logic        d_st = 1'b0;
  logic [2:0]  flags;
  logic [2:0]  fl = 3'h0;    // model of the suspend flags
  logic        abort_p;
  logic        undef_p;
  logic        strobe;
  logic        id_act;     // identification stream in progress
  logic        allowed;
  logic        ok;
  logic [7:0]  opcode;
  cmd_class_t  cls;
  cmd_class_t  c;
  logic [31:0] rng = 32'h00002CC5;
  logic [31:0] q;
  int          mismatches = 0;
  int          check_count = 0;
  int          aborts = 0;
  int          undefs = 0;
  int          strobes = 0;
  int          ids = 0;
  int          ab, ud, st, i, s, id0;
  logic [7:0]  ops [14] = '{8'hD2, 8'h0B, 8'h35, 8'h81, 8'h50, 8'h58, 8'h84,
                             8'hD7, 8'h57, 8'h9F, 8'h3D, 8'h9B, 8'hB0, 8'hF0};
  logic [31:0] rtx [5] = '{32'hF0000000, 32'hF0000000, 32'hF0000000, 32'hF0000000, 32'hF0000001};
  logic [6:0]  rbits [5] = '{7'h20, 7'h28, 7'h24, 7'h18, 7'h20};
  int          rexp [5] = '{1, 1, 0, 0, 0};

  always #25 clock = ~clock;

  spi_link_if link ();

  flash_cmd_device #(.MANUFACTURER_CODE(MAKER), .FAMILY_CODE(DEV1[7:5]), .DENSITY_CODE(DEV1[4:0]),
    .SUB_CODE(DEV2[7:5]), .PRODUCT_VARIANT(DEV2[4:0]), .SILICON_REVISION(EXT_INFO[4:0])) flash_cmd_device_inst (
    .clock(clock), .nrst(nrst), .link(link), .b_self_timed(b_st), .d_self_timed(d_st),
    .suspend_prog_one(susp[0]), .suspend_prog_two(susp[1]), .suspend_erase(susp[2]), .resume(susp[3]),
    .program_suspend_buf_one(flags[0]), .program_suspend_buf_two(flags[1]), .erase_suspend_flag(flags[2]),
    .array_abort(abort_p), .page_undefined(undef_p), .cmd_strobe(strobe), .cmd_opcode(opcode),
    .cmd_class(cls), .cmd_allowed(allowed), .id_active(id_act));

  flash_cmd_host flash_cmd_host_inst (.clock(clock), .nrst(nrst), .link(link), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  flash_link_checker flash_link_checker_inst (.clock(clock), .nrst(nrst), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .so(link.so), .so_oe(link.so_oe), .miso(link.miso));

  // pulses counted mid-cycle, clear of the edge that launches them
  always @(negedge clock) begin
    aborts += int'(abort_p === 1'b1);
    undefs += int'(undef_p === 1'b1);
    strobes += int'(strobe === 1'b1);
    ids += int'(id_act === 1'b1);
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // one bus cycle; waitrequest is judged as it stood before each edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ws;
    int   n;
    @(posedge clock);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    ws = 1'b1;
    n = 0;
    while (ws !== 1'b0 && n < 20) begin
      #1;
      ws = waitrequest;
      // read data already stands here and holds through the accepting edge
      r = readdata;
      @(posedge clock);
      n++;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (ws !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
  endtask : bus

  // load, start and wait out one frame; TX must be rewritten every time
  task frame(input logic [31:0] tx, input logic [6:0] bits);
    int n;
    bus(1'b1, REG_TX, tx, q);
    bus(1'b1, REG_CTRL, {25'h0, bits}, q);
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 2000) begin
      bus(1'b0, REG_CTRL, 32'h0, q);
      n++;
    end
    if (q[0] !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
    repeat (8) @(posedge clock);
  endtask : frame

  task pulse(input int k);
    @(posedge clock);
    susp <= 4'(1 << k);
    @(posedge clock);
    susp <= 4'h0;
    fl = (k == 3) ? 3'h0 : fl | 3'(1 << k);
  endtask : pulse

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    bus(1'b1, REG_DIV, 32'h7, q);
    bus(1'b0, 5'h14, 32'h0, q);
    check("unmapped", q, 32'h0);
    // a cut-short read first, then a full one and an overrun one
    frame(32'h9F000000, 7'h15);
    frame(32'h9F000000, 7'h30);
    bus(1'b0, REG_RX_HI, 32'h0, q);
    check("maker", q & 32'hFF, 32'(MAKER));
    bus(1'b0, REG_RX_LO, 32'h0, q);
    check("id bytes", q, {DEV1, DEV2, 8'h01, EXT_INFO});
    frame(32'h9F000000, 7'h38);
    bus(1'b0, REG_RX_HI, 32'h0, q);
    check("device one", q & 32'hFF, 32'(DEV1));
    bus(1'b0, REG_RX_LO, 32'h0, q);
    check("id tail", q, {DEV2, 8'h01, EXT_INFO, 8'hFF});
    $display("test identification done");
    for (int k = 0; k < 5; k++) begin
      pulse(k % 3);
      ab = aborts;
      ud = undefs;
      frame(rtx[k], rbits[k]);
      fl = (rexp[k] == 1) ? 3'h0 : fl;
      check("abort", 32'(aborts - ab), 32'(rexp[k]));
      check("page undefined", 32'(undefs - ud), 32'(rexp[k]));
      check("suspend flags", 32'(flags), 32'(fl));
    end
    $display("test software reset done");
    for (int n = 0; n < 42; n++) begin
      rng = xs(rng);
      i = n % 14;
      s = int'(rng[9:8]);
      pulse((s == 3) ? 2 : 3);
      b_st <= (s == 1);
      d_st <= (s == 2);
      st = strobes;
      id0 = ids;
      frame({ops[i], 24'h0}, 7'h08);
      c = i < 3 ? CLASS_A : i < 6 ? CLASS_B : i < 10 ? CLASS_C : i < 12 ? CLASS_D : CLASS_NONE;
      ok = ops[i] == 8'hF0 || s == 0 || (s == 1 && (c == CLASS_C || ops[i] == 8'hB0))
        || (s == 2 && (ops[i] == 8'hD7 || ops[i] == 8'h57)) || (s == 3 && c != CLASS_B && c != CLASS_D);
      check("strobe", 32'(strobes - st), 32'h1);
      check("opcode", 32'(opcode), 32'(ops[i]));
      check("class", 32'(cls), 32'(c));
      check("allowed", 32'(allowed), 32'(ok));
      check("id active", 32'(ids != id0), 32'(ops[i] == 8'h9F));
    end
    $display("test command classes done");
    give_verdict();
  end
endmodule : flash_id_reset_cmd_arbiter_bench

// *** tb/flash_link_checker.sv ***
/*
  Checker for the serial link between host controller and flash device.
  Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module flash_link_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic so,
  input wire logic so_oe,
  input wire logic miso
);
  logic       sclk_q;    // serial clock one cycle back
  logic [6:0] rise_cnt;  // rising serial edges in this frame
  logic [6:0] fall_cnt;  // falling serial edges in this frame
  logic [7:0] op;        // first byte of the frame
  logic [7:0] hcnt;      // cycles since the serial clock last moved
  logic       rise;
  logic       fall;
  logic       chg;
  logic       id_frame;  // opcode 9F fully received

  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;
  assign chg = sclk ^ sclk_q;
  assign id_frame = !cs_n && op == 8'h9F && rise_cnt >= 7'h08;

  // edge counters restart with every frame, so a stale opcode never counts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      hcnt <= 8'h00;
      rise_cnt <= 7'h00;
      fall_cnt <= 7'h00;
      op <= 8'h00;
    end else begin
      sclk_q <= sclk;
      hcnt <= chg ? 8'h00 : hcnt + {7'h00, hcnt != 8'hFF};
      rise_cnt <= cs_n ? 7'h00 : rise_cnt + {6'h00, rise};
      fall_cnt <= cs_n ? 7'h00 : fall_cnt + {6'h00, fall};
      if (rise && !cs_n && rise_cnt < 7'h08) begin
        op <= {op[6:0], mosi};
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_id_start: assert property (fall && id_frame && rise_cnt == 7'h08 |-> ##[1:6] so_oe)
    else $error("id output did not start");
  a_id_float: assert property (fall && id_frame && fall_cnt == 7'h2F |-> ##[1:6] !so_oe)
    else $error("id output not floated after last byte");
  a_only_id: assert property (so_oe && !cs_n |-> id_frame && fall_cnt <= 7'h30)
    else $error("output driven outside id data");
  a_float_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("output still driven after release");
  a_idle_quiet: assert property (cs_n [*8] |-> !so_oe)
    else $error("output driven while idle");
  a_float_high: assert property (id_frame && fall_cnt > 7'h30 |-> miso)
    else $error("line not released after id data");
  a_so_on_fall: assert property ($changed(so) |-> !sclk && hcnt <= 8'h06)
    else $error("device output moved away from a falling edge");
  a_so_steady: assert property ($rose(sclk) |-> $stable(so) [*6])
    else $error("device output moved while clock high");
  a_mosi_steady: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  a_id_clock: assert property (chg && id_frame |-> hcnt >= 8'h09)
    else $error("id read clocked too fast");
endmodule : flash_link_checker
